// File: rtl/gtl_pkg.sv
// gtl_pkg: constants shared by both ends of the instrument bus port.
// assumes: one 200 MHz clock, all bus lines low-true on the wire.
package gtl_pkg;
   // ********************
   // command codes
   // ********************
   localparam logic [6:0] GTL_LAD_BASE = 7'h20;
   localparam logic [6:0] GTL_TAD_BASE = 7'h40;
   localparam logic [6:0] GTL_UNL = 7'h3f;
   localparam logic [6:0] GTL_UNT = 7'h5f;
   localparam logic [6:0] GTL_CMD_DCL = 7'h14;
   localparam logic [6:0] GTL_CMD_SDC = 7'h04;
   localparam logic [4:0] GTL_ADDR_ILLEGAL = 5'h1f;
   localparam logic [7:0] GTL_CHR_LF = 8'h0a;
   localparam logic [7:0] GTL_CHR_CR = 8'h0d;
   // ********************
   // register map of the controller end
   // ********************
   localparam logic [3:0] GTL_REG_CTRL = 4'h0;
   localparam logic [3:0] GTL_REG_STAT = 4'h1;
   localparam logic [3:0] GTL_REG_TXD = 4'h2;
   localparam logic [3:0] GTL_REG_RXD = 4'h3;
   localparam int GTL_CTRL_IFC = 0;
   localparam int GTL_CTRL_ATN = 1;
   localparam int GTL_CTRL_EOI = 2;
   localparam int GTL_CTRL_LSN = 3;
   localparam logic [31:0] GTL_CTRL_RST = 32'h0000_0000;
   // settle time between data placement and valid strobe
   localparam int GTL_SETTLE_NS = 10;
   localparam int GTL_CLK_MHZ = 200;
   localparam int GTL_SETTLE_CYC = (GTL_SETTLE_NS * GTL_CLK_MHZ + 999) / 1000;
endpackage

// File: rtl/gtl_bus_if.sv
// gtl_bus_if: the sixteen shared lines with per-party drive signals.
// assumes: open-collector wire, a line is low when any party pulls it.
`timescale 1ns/1ps
`default_nettype none
interface gtl_bus_if;
   // pull enables, high means this party pulls the line low
   logic [7:0] dev_dio_oe;
   logic dev_dav_oe, dev_nrfd_oe, dev_ndac_oe, dev_eoi_oe, dev_srq_oe;
   logic [7:0] ctl_dio_oe;
   logic ctl_dav_oe, ctl_nrfd_oe, ctl_ndac_oe, ctl_eoi_oe, ctl_atn_oe, ctl_ifc_oe, ctl_ren_oe;
   // wire levels, 0 = asserted
   logic [7:0] dio_n;
   logic dav_n, nrfd_n, ndac_n, eoi_n, atn_n, ifc_n, srq_n, ren_n;
   assign dio_n = ~(dev_dio_oe | ctl_dio_oe);
   assign dav_n = ~(dev_dav_oe | ctl_dav_oe);
   assign nrfd_n = ~(dev_nrfd_oe | ctl_nrfd_oe);
   assign ndac_n = ~(dev_ndac_oe | ctl_ndac_oe);
   assign eoi_n = ~(dev_eoi_oe | ctl_eoi_oe);
   assign atn_n = ~ctl_atn_oe;
   assign ifc_n = ~ctl_ifc_oe;
   assign srq_n = ~dev_srq_oe;
   assign ren_n = ~ctl_ren_oe;
   modport dev (output dev_dio_oe, dev_dav_oe, dev_nrfd_oe, dev_ndac_oe, dev_eoi_oe, dev_srq_oe,
      input dio_n, dav_n, nrfd_n, ndac_n, eoi_n, atn_n, ifc_n, ren_n);
   modport ctl (output ctl_dio_oe, ctl_dav_oe, ctl_nrfd_oe, ctl_ndac_oe, ctl_eoi_oe, ctl_atn_oe,
      ctl_ifc_oe, ctl_ren_oe, input dio_n, dav_n, nrfd_n, ndac_n, eoi_n, srq_n);
endinterface
`default_nettype wire

// File: rtl/gtl_device.sv
// gtl_device: instrument end, talker and listener on the bus.
// assumes: bus lines asynchronous to clk, switches static or slow.
//
`timescale 1ns/1ps
`default_nettype none
module gtl_device
   import gtl_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // bus side
   gtl_bus_if.dev bus,
   // switches
   input wire logic [4:0] sw_addr,
   input wire logic sw_dual,
   input wire logic sw_talk_only,
   input wire logic sw_eoi_en,
   // outgoing bytes from instrument logic
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_last,
   output logic tx_ready,
   // received data bytes
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_end,
   // status
   output logic is_listener,
   output logic is_talker,
   output logic dev_clear,
   output logic addr_bad
);
   // ********************
   // input synchroniser
   // ********************
   logic [12:0] s1_r, s2_r;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1_r <= 13'h1fff;
         s2_r <= 13'h1fff;
      end else begin
         s1_r <= {bus.dio_n, bus.dav_n, bus.ndac_n, bus.nrfd_n, bus.eoi_n, bus.ifc_n};
         s2_r <= s1_r;
      end
   end
   // active-high views of the wire
   wire [7:0] dio = ~s2_r[12:5];
   wire dav = ~s2_r[4];
   wire ndac = ~s2_r[3];
   wire nrfd = ~s2_r[2];
   wire eoi = ~s2_r[1];
   wire ifc = ~s2_r[0];
   // atn kept on its own pair; it has no part in the packed vector
   logic atn_s1_r, atn_s2_r;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         atn_s1_r <= 1'b1;
         atn_s2_r <= 1'b1;
      end else begin
         atn_s1_r <= bus.atn_n;
         atn_s2_r <= atn_s1_r;
      end
   end
   wire atn = ~atn_s2_r;
   // switches are pins too; a flip in mid-byte must not split one compare
   logic [7:0] sw1_r, sw2_r;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sw1_r <= 8'h00;
         sw2_r <= 8'h00;
      end else begin
         sw1_r <= {sw_addr, sw_dual, sw_talk_only, sw_eoi_en};
         sw2_r <= sw1_r;
      end
   end
   wire [4:0] addr_sw = sw2_r[7:3];
   wire dual_sw = sw2_r[2];
   wire talk_only_sw = sw2_r[1];
   wire eoi_en_sw = sw2_r[0];

   // ********************
   // address compare
   // ********************
   function automatic logic addr_hit(input logic [4:0] code, input logic [4:0] mine,
         input logic dual);
      addr_hit = dual ? (code[4:1] == mine[4:1]) : (code == mine);
   endfunction
   wire addr_ok = (addr_sw != GTL_ADDR_ILLEGAL);
   wire [6:0] cmd = dio[6:0];
   wire grp_lad = (cmd[6:5] == 2'b01);
   wire grp_tad = (cmd[6:5] == 2'b10);
   wire my_lad = grp_lad && addr_ok && addr_hit(cmd[4:0], addr_sw, dual_sw) && cmd != GTL_UNL;
   wire my_tad = grp_tad && addr_ok && addr_hit(cmd[4:0], addr_sw, dual_sw) && cmd != GTL_UNT;

   // ********************
   // acceptor handshake
   // ********************
   typedef enum logic [1:0] {GTL_A_IDLE, GTL_A_READY, GTL_A_HOLD} gtl_acc_t;
   gtl_acc_t acc_r, acc_nxt;
   logic lsn_r, tlk_r, nrfd_oe_r, ndac_oe_r;
   logic rxv_r, rxe_r, dcl_r;
   logic [7:0] rxd_r;
   // take part when a command comes, or data while addressed; talk-only never listens
   wire acc_on = !talk_only_sw && (atn || lsn_r);
   wire take = (acc_r == GTL_A_READY) && dav;
   always_comb begin
      acc_nxt = acc_r;
      case (acc_r)
         GTL_A_IDLE: if (acc_on) acc_nxt = GTL_A_READY;
         GTL_A_READY: if (!acc_on) acc_nxt = GTL_A_IDLE; else if (dav) acc_nxt = GTL_A_HOLD;
         GTL_A_HOLD: if (!dav) acc_nxt = acc_on ? GTL_A_READY : GTL_A_IDLE;
         default: acc_nxt = GTL_A_IDLE;
      endcase
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         acc_r <= GTL_A_IDLE;
         lsn_r <= 1'b0;
         tlk_r <= 1'b0;
         nrfd_oe_r <= 1'b0;
         ndac_oe_r <= 1'b0;
         rxv_r <= 1'b0;
         rxe_r <= 1'b0;
         rxd_r <= 8'h00;
         dcl_r <= 1'b0;
      end else if (ifc) begin
         acc_r <= GTL_A_IDLE;
         lsn_r <= 1'b0;
         tlk_r <= 1'b0;
         nrfd_oe_r <= 1'b0;
         ndac_oe_r <= 1'b0;
         rxv_r <= 1'b0;
         dcl_r <= 1'b0;
      end else begin
         acc_r <= acc_nxt;
         // ready in IDLE and READY; busy only while holding
         nrfd_oe_r <= (acc_nxt == GTL_A_HOLD);
         // ndac held until the byte is taken
         ndac_oe_r <= (acc_nxt == GTL_A_READY);
         rxv_r <= take && !atn;
         // eoi beside a command is not an end mark
         rxe_r <= take && !atn && eoi;
         if (take && !atn)
            rxd_r <= dio;
         dcl_r <= take && atn && (cmd == GTL_CMD_DCL ||
            (cmd == GTL_CMD_SDC && lsn_r));
         if (take && atn) begin
            if (my_lad) lsn_r <= 1'b1;
            else if (cmd == GTL_UNL) lsn_r <= 1'b0;
            if (my_tad) tlk_r <= 1'b1;
            else if (grp_tad || cmd == GTL_UNT) tlk_r <= 1'b0;
         end
      end
   end

   // ********************
   // source handshake
   // ********************
   typedef enum logic [1:0] {GTL_S_IDLE, GTL_S_SETUP, GTL_S_VALID, GTL_S_DONE} gtl_src_t;
   gtl_src_t src_r;
   logic [7:0] dio_oe_r;
   logic dav_oe_r, eoi_oe_r, txr_r;
   logic [3:0] set_cnt_r;
   wire talk_en = (talk_only_sw || tlk_r) && !atn;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         src_r <= GTL_S_IDLE;
         dio_oe_r <= 8'h00;
         dav_oe_r <= 1'b0;
         eoi_oe_r <= 1'b0;
         txr_r <= 1'b0;
         set_cnt_r <= 4'h0;
      end else if (ifc) begin
         src_r <= GTL_S_IDLE;
         dio_oe_r <= 8'h00;
         dav_oe_r <= 1'b0;
         eoi_oe_r <= 1'b0;
         txr_r <= 1'b0;
      end else begin
         txr_r <= 1'b0;
         case (src_r)
            GTL_S_IDLE: if (talk_en && tx_valid && !txr_r && !nrfd && ndac) begin
               dio_oe_r <= tx_data;
               eoi_oe_r <= eoi_en_sw && tx_last;
               set_cnt_r <= 4'(GTL_SETTLE_CYC);
               txr_r <= 1'b1;
               src_r <= GTL_S_SETUP;
            end
            GTL_S_SETUP: if (set_cnt_r == 4'h0) begin
               dav_oe_r <= 1'b1;
               src_r <= GTL_S_VALID;
            end else begin
               set_cnt_r <= set_cnt_r - 4'h1;
            end
            GTL_S_VALID: if (!ndac) begin
               dav_oe_r <= 1'b0;
               src_r <= GTL_S_DONE;
            end
            GTL_S_DONE: begin
               dio_oe_r <= 8'h00;
               eoi_oe_r <= 1'b0;
               src_r <= GTL_S_IDLE;
            end
            default: src_r <= GTL_S_IDLE;
         endcase
      end
   end

   // ********************
   // outputs
   // ********************
   logic bad_r;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) bad_r <= 1'b0;
      else bad_r <= !addr_ok;
   end
   assign bus.dev_dio_oe = dio_oe_r;
   assign bus.dev_dav_oe = dav_oe_r;
   assign bus.dev_nrfd_oe = nrfd_oe_r;
   assign bus.dev_ndac_oe = ndac_oe_r;
   assign bus.dev_eoi_oe = eoi_oe_r;
   assign bus.dev_srq_oe = 1'b0;
   assign tx_ready = txr_r;
   assign rx_valid = rxv_r;
   assign rx_data = rxd_r;
   assign rx_end = rxe_r;
   assign is_listener = lsn_r;
   assign is_talker = tlk_r;
   assign dev_clear = dcl_r;
   assign addr_bad = bad_r;
endmodule // gtl_device
`default_nettype wire

// File: rtl/gtl_ctl.sv
// gtl_ctl: controller end, driven by software through a small register port.
// assumes: bus lines asynchronous; software keeps one talker addressed.
`timescale 1ns/1ps
`default_nettype none
module gtl_ctl
   import gtl_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // bus side
   gtl_bus_if.ctl bus
);
   // ********************
   // synchroniser
   // ********************
   logic [11:0] s1_r, s2_r;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1_r <= 12'hfff;
         s2_r <= 12'hfff;
      end else begin
         s1_r <= {bus.dio_n, bus.dav_n, bus.nrfd_n, bus.ndac_n, bus.eoi_n};
         s2_r <= s1_r;
      end
   end
   wire [7:0] dio = ~s2_r[11:4];
   wire dav = ~s2_r[3];
   wire nrfd = ~s2_r[2];
   wire ndac = ~s2_r[1];
   wire eoi = ~s2_r[0];

   // ********************
   // registers
   // ********************
   logic [3:0] ctrl_r;
   logic [7:0] txd_r, rxd_r, dio_oe_r;
   logic busy_r, rxv_r, rxe_r, dav_oe_r, ndac_oe_r, nrfd_oe_r;
   logic [3:0] cnt_r;
   logic [31:0] rdata_r;
   typedef enum logic [1:0] {GTL_C_IDLE, GTL_C_SETUP, GTL_C_VALID, GTL_C_DONE} gtl_cst_t;
   gtl_cst_t st_r;
   wire wr_ctrl = reg_wr && reg_addr == GTL_REG_CTRL;
   wire wr_txd = reg_wr && reg_addr == GTL_REG_TXD;
   wire rd_rxd = reg_rd && reg_addr == GTL_REG_RXD;
   wire lsn_on = ctrl_r[GTL_CTRL_LSN] && !ctrl_r[GTL_CTRL_ATN];
   wire got = lsn_on && dav && !rxv_r && ndac_oe_r;
   wire [31:0] stat_w = {28'h0, rxe_r, rxv_r, busy_r, 1'b0};
   wire [31:0] rd_mux = (reg_addr == GTL_REG_CTRL) ? {28'h0, ctrl_r} :
      (reg_addr == GTL_REG_STAT) ? stat_w :
      (reg_addr == GTL_REG_TXD) ? {24'h0, txd_r} :
      (reg_addr == GTL_REG_RXD) ? {24'h0, rxd_r} : 32'h0;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_r <= GTL_CTRL_RST[3:0];
         txd_r <= 8'h00;
         rxd_r <= 8'h00;
         rxv_r <= 1'b0;
         rxe_r <= 1'b0;
         rdata_r <= 32'h0;
         ndac_oe_r <= 1'b0;
         nrfd_oe_r <= 1'b0;
      end else begin
         rdata_r <= reg_rd ? rd_mux : 32'h0;
         if (wr_ctrl) ctrl_r <= reg_wdata[3:0];
         if (wr_txd && !busy_r) txd_r <= reg_wdata[7:0];
         // acceptor for data while software listens
         ndac_oe_r <= lsn_on && !(got || (rxv_r && dav));
         nrfd_oe_r <= lsn_on && (rxv_r || dav);
         if (got) begin
            rxd_r <= dio;
            rxe_r <= eoi;
         end
         if (got) rxv_r <= 1'b1; // set beats clear
         else if (rd_rxd) rxv_r <= 1'b0;
      end
   end

   // ********************
   // source of command and data bytes
   // ********************
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= GTL_C_IDLE;
         busy_r <= 1'b0;
         dio_oe_r <= 8'h00;
         dav_oe_r <= 1'b0;
         cnt_r <= 4'h0;
      end else if (ctrl_r[GTL_CTRL_IFC]) begin
         st_r <= GTL_C_IDLE;
         busy_r <= 1'b0;
         dio_oe_r <= 8'h00;
         dav_oe_r <= 1'b0;
      end else begin
         case (st_r)
            GTL_C_IDLE: if (wr_txd) busy_r <= 1'b1;
               else if (busy_r && !nrfd && ndac) begin
                  dio_oe_r <= txd_r;
                  cnt_r <= 4'(GTL_SETTLE_CYC);
                  st_r <= GTL_C_SETUP;
               end
            GTL_C_SETUP: if (cnt_r == 4'h0) begin
               dav_oe_r <= 1'b1;
               st_r <= GTL_C_VALID;
            end else cnt_r <= cnt_r - 4'h1;
            GTL_C_VALID: if (!ndac) begin
               dav_oe_r <= 1'b0;
               st_r <= GTL_C_DONE;
            end
            GTL_C_DONE: begin
               dio_oe_r <= 8'h00;
               busy_r <= 1'b0;
               st_r <= GTL_C_IDLE;
            end
            default: st_r <= GTL_C_IDLE;
         endcase
      end
   end
   assign reg_rdata = rdata_r;
   assign bus.ctl_dio_oe = dio_oe_r;
   assign bus.ctl_dav_oe = dav_oe_r;
   assign bus.ctl_nrfd_oe = nrfd_oe_r;
   assign bus.ctl_ndac_oe = ndac_oe_r;
   assign bus.ctl_eoi_oe = ctrl_r[GTL_CTRL_EOI] && dav_oe_r;
   assign bus.ctl_atn_oe = ctrl_r[GTL_CTRL_ATN];
   assign bus.ctl_ifc_oe = ctrl_r[GTL_CTRL_IFC];
   assign bus.ctl_ren_oe = 1'b0;
endmodule // gtl_ctl
`default_nettype wire

// File: dv/gtl_properties.sv
// gtl_properties: wire-level checks of both ends of the instrument bus.
// assumes: instantiated in tb beside the interface, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module gtl_properties (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // device pulls
   input wire logic [7:0] dev_dio_oe,
   input wire logic dev_dav_oe,
   input wire logic dev_ndac_oe,
   input wire logic dev_eoi_oe,
   // controller pulls
   input wire logic [7:0] ctl_dio_oe,
   input wire logic ctl_dav_oe,
   // wire levels
   input wire logic dav_n,
   input wire logic nrfd_n,
   input wire logic ndac_n,
   input wire logic atn_n,
   input wire logic ifc_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ********************
   // handshake order
   // ********************
   a_dev_data_hold: assert property ($past(dev_dav_oe) && ifc_n |-> $stable(dev_dio_oe))
      else $error("device data moved while valid");
   a_ctl_data_hold: assert property ($past(ctl_dav_oe) && ifc_n |-> $stable(ctl_dio_oe))
      else $error("controller data moved while valid");
   a_dev_data_first: assert property ($rose(dev_dav_oe) |-> $past(dev_dio_oe, 2) == dev_dio_oe)
      else $error("device valid before data settled");
   a_ctl_data_first: assert property ($rose(ctl_dav_oe) |-> $past(ctl_dio_oe, 2) == ctl_dio_oe)
      else $error("controller valid before data settled");
   a_dev_wait_ready: assert property ($rose(dev_dav_oe) |-> nrfd_n)
      else $error("device sent while a listener was not ready");
   a_dev_dav_release: assert property ($fell(dev_dav_oe) && ifc_n |-> ndac_n)
      else $error("device dropped valid before acceptance");
   a_ctl_dav_release: assert property ($fell(ctl_dav_oe) && ifc_n |-> ndac_n)
      else $error("controller dropped valid before acceptance");
   // data mode must have settled so an unaddressed release is not mistaken for acceptance
   a_dev_ndac_hold: assert property ($fell(dev_ndac_oe) && ifc_n && atn_n && $past(atn_n, 4)
      |-> !dav_n)
      else $error("device released accept without a byte");
   a_ifc_quiet: assert property (!ifc_n [*4] |-> !dev_dav_oe && dev_dio_oe == 8'h00 && !dev_eoi_oe)
      else $error("device still driving during clear");
   a_eoi_no_atn: assert property (dev_eoi_oe |-> atn_n)
      else $error("device end mark during command mode");
   c_dev_talk: cover property ($rose(dev_dav_oe));
   c_ctl_talk: cover property ($rose(ctl_dav_oe));
   c_ifc: cover property ($fell(ifc_n));
   c_eoi: cover property ($rose(dev_eoi_oe));
endmodule // gtl_properties
`default_nettype wire

// File: dv/gtl_tb.sv
// tb: controller end and device end joined by the bus interface.
// assumes: software register port on the controller, device user side driven here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb;
   import gtl_pkg::*;
   logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, last_rd = 32'h0, e, m;
   logic [4:0] sw_addr = 5'h05;
   logic sw_dual = 1'b0, sw_talk_only = 1'b0, sw_eoi_en = 1'b0, tx_valid = 1'b0, tx_last = 1'b0;
   logic [7:0] tx_data = 8'h00, rx_data, b2;
   logic [8:0] rx_exp;
   logic eoi_on = 1'b0;
   logic tx_ready, rx_valid, rx_end, is_listener, is_talker, dev_clear, addr_bad;
   // end mark beside each expected byte
   logic [8:0] exp_rx[$];
   logic [31:0] exp_rd[$], msk_rd[$];
   int err_count = 0, samples_checked = 0, clr_cnt = 0, seed = 98, i, c0;
   always #2.5 clk = ~clk;
   gtl_bus_if bus_inst();
   gtl_device gtl_device_inst (.clk(clk), .sys_rst(sys_rst), .bus(bus_inst.dev), .sw_addr(sw_addr),
      .sw_dual(sw_dual), .sw_talk_only(sw_talk_only), .sw_eoi_en(sw_eoi_en), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_end(rx_end), .is_listener(is_listener), .is_talker(is_talker),
      .dev_clear(dev_clear), .addr_bad(addr_bad));
   gtl_ctl gtl_ctl_inst (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus(bus_inst.ctl));
   gtl_properties gtl_properties_inst (.clk(clk), .sys_rst(sys_rst),
      .dev_dio_oe(bus_inst.dev_dio_oe), .dev_dav_oe(bus_inst.dev_dav_oe),
      .dev_ndac_oe(bus_inst.dev_ndac_oe), .dev_eoi_oe(bus_inst.dev_eoi_oe),
      .ctl_dio_oe(bus_inst.ctl_dio_oe), .ctl_dav_oe(bus_inst.ctl_dav_oe), .dav_n(bus_inst.dav_n),
      .nrfd_n(bus_inst.nrfd_n), .ndac_n(bus_inst.ndac_n), .atn_n(bus_inst.atn_n),
      .ifc_n(bus_inst.ifc_n));
   // ********************
   // result monitor
   // ********************
   always @(posedge clk) begin
      rd_d <= reg_rd;
      if (dev_clear === 1'b1) clr_cnt <= clr_cnt + 1;
      if (rd_d) begin
         last_rd <= reg_rdata;
         e = exp_rd.pop_front();
         m = msk_rd.pop_front();
         if (m != 32'h0) `CHK(reg_rdata & m, e)
      end
      if (rx_valid === 1'b1) begin
         if (exp_rx.size() == 0) begin
            err_count++;
            $display("[FAIL] %0t unexpected received byte", $time);
         end else begin
            rx_exp = exp_rx.pop_front();
            `CHK({rx_end, rx_data}, rx_exp)
         end
      end
   end
   // ********************
   // drivers
   // ********************
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] ex, input logic [31:0] mk);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_rd.push_back(ex);
      msk_rd.push_back(mk);
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic wait_stat(input int bitn, input logic val);
      int n;
      for (n = 0; n < 100; n++) begin
         rd(GTL_REG_STAT, 32'h0, 32'h0);
         if (last_rd[bitn] === val) break;
      end
      if (n == 100) begin
         err_count++;
         $display("[FAIL] %0t status wait timed out", $time);
      end
   endtask
   // one byte from the controller, command when atn is set
   task automatic send(input logic atn, input logic lsn, input logic [7:0] d);
      wr(GTL_REG_CTRL, {28'h0, lsn, eoi_on, atn, 1'b0});
      wr(GTL_REG_TXD, {24'h0, d});
      wait_stat(1, 1'b0);
   endtask
   task automatic tx(input logic [7:0] d, input logic l);
      int n;
      // the device sees switch changes two cycles late
      repeat (3) @(posedge clk);
      tx_valid <= 1'b1;
      tx_data <= d;
      tx_last <= l;
      for (n = 0; n < 200; n++) begin
         @(posedge clk);
         #1;
         if (tx_ready === 1'b1) break;
      end
      @(posedge clk);
      tx_valid <= 1'b0;
      if (n == 200) begin
         err_count++;
         $display("[FAIL] %0t device never took byte", $time);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      err_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      results();
   end
   // ********************
   // tests
   // ********************
   initial begin
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      #1;
      `CHK({is_listener, is_talker}, 2'b00)
      `CHK({bus_inst.dio_n, bus_inst.dav_n, bus_inst.nrfd_n, bus_inst.ndac_n}, 11'h7ff)
      $display("test reset done");
      send(1'b1, 1'b0, {1'b0, GTL_LAD_BASE} + {3'h0, sw_addr});
      `CHK(is_listener, 1'b1)
      for (i = 0; i < 4; i++) begin
         b2 = 8'($random(seed));
         eoi_on = (i == 3);
         exp_rx.push_back({eoi_on, b2});
         send(1'b0, 1'b0, b2);
      end
      eoi_on = 1'b0;
      $display("test listen done");
      send(1'b1, 1'b0, {1'b0, GTL_UNL});
      `CHK(is_listener, 1'b0)
      b2 = 8'($random(seed));
      send(1'b0, 1'b1, b2);
      rd(GTL_REG_RXD, {24'h0, b2}, 32'hff);
      c0 = clr_cnt;
      send(1'b1, 1'b0, {1'b0, GTL_CMD_DCL});
      `CHK(clr_cnt, c0 + 1)
      send(1'b1, 1'b0, {1'b0, GTL_CMD_SDC});
      `CHK(clr_cnt, c0 + 1)
      $display("test unlisten done");
      send(1'b1, 1'b0, {1'b0, GTL_TAD_BASE} + {3'h0, sw_addr});
      `CHK(is_talker, 1'b1)
      wr(GTL_REG_CTRL, 32'h8);
      for (i = 0; i < 6; i++) begin
         @(posedge clk);
         sw_eoi_en <= (i < 5);
         b2 = (i > 3) ? GTL_CHR_LF : 8'($random(seed));
         tx(b2, i > 3);
         wait_stat(2, 1'b1);
         rd(GTL_REG_STAT, {28'h0, (i == 4), 3'h0}, 32'h8);
         rd(GTL_REG_RXD, {24'h0, b2}, 32'hff);
      end
      send(1'b1, 1'b0, {1'b0, GTL_TAD_BASE} + {3'h0, sw_addr} + 8'h01);
      `CHK(is_talker, 1'b0)
      $display("test talk done");
      @(posedge clk);
      sw_talk_only <= 1'b1;
      wr(GTL_REG_CTRL, 32'h8);
      b2 = 8'($random(seed));
      tx(b2, 1'b0);
      wait_stat(2, 1'b1);
      rd(GTL_REG_RXD, {24'h0, b2}, 32'hff);
      @(posedge clk);
      sw_talk_only <= 1'b0;
      $display("test talk only done");
      sw_dual <= 1'b1;
      send(1'b1, 1'b0, {1'b0, GTL_LAD_BASE} + {3'h0, sw_addr ^ 5'h01});
      `CHK(is_listener, 1'b1)
      send(1'b1, 1'b0, {1'b0, GTL_CMD_SDC});
      `CHK(clr_cnt, c0 + 2)
      wr(GTL_REG_CTRL, 32'h1);
      repeat (8) @(posedge clk);
      #1;
      `CHK(is_listener, 1'b0)
      wr(GTL_REG_CTRL, 32'h0);
      sw_dual <= 1'b0;
      $display("test dual and clear done");
      sw_addr <= GTL_ADDR_ILLEGAL;
      repeat (6) @(posedge clk);
      #1;
      `CHK(addr_bad, 1'b1)
      @(posedge clk);
      sw_addr <= 5'h05;
      repeat (6) @(posedge clk);
      #1;
      `CHK(addr_bad, 1'b0)
      $display("test address done");
      results();
   end
endmodule // tb
`default_nettype wire
